// ==== hbfs_pkg.sv ====
// Constants shared by the H-bridge fault and sleep controller.
// Assumes a single 100 MHz core clock.
package hbfs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RETRY_TIME_US = 1000;
  // Overcurrent retry delay in core clock cycles
  localparam int unsigned RETRY_CYCLES = (RETRY_TIME_US * 1000) / CLK_PERIOD_NS;
  // Qualification time of a current-limit event before it trips
  localparam int unsigned QUAL_TIME_NS = 3000;
  localparam int unsigned QUAL_CYCLES = (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SWITCH_COUNT = 4;
  localparam int unsigned QUAL_WIDTH = 10;
  localparam int unsigned RETRY_WIDTH = 20;
  // Per-switch drive encoding: bit1 high-side on, bit0 low-side on
  localparam logic [1:0] DRV_OFF = 2'h0;
  localparam logic [1:0] DRV_HIGH = 2'h2;
  localparam logic [1:0] DRV_LOW = 2'h1;
  typedef enum logic [1:0] {HBFS_SLEEP, HBFS_RUN, HBFS_OC_WAIT, HBFS_HOT} hbfs_state_t;
endpackage

// ==== hbfs_qual.sv ====
// Current-limit qualification filter for one bridge switch.
// Assumes the limit flag is synchronous to core_clk.
module hbfs_qual
  import hbfs_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic clr, // Restart counting
  input wire logic limit_active, // Switch is in current limit
  output logic qualified // Limit persisted beyond the qualification time
);
  logic [QUAL_WIDTH-1:0] cnt_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (clr || !limit_active) begin
      cnt_r <= '0;
    end else if (cnt_r != QUAL_WIDTH'(QUAL_CYCLES)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign qualified = (cnt_r == QUAL_WIDTH'(QUAL_CYCLES));
endmodule

// ==== hbfs_ctrl.sv ====
// H-bridge sleep, overcurrent retry, overheat and lockout control.
// Assumes all inputs are synchronous to core_clk; analog sense is outside.
// How it works
// - Low sleep request powers down everything except wake logic.
// - Current limit longer than qualification time turns off all four switches.
// - Bridge re-enables itself about 1 ms after an overcurrent shutdown.
// - Either high-side or low-side switch fault triggers the shutdown.
// - Overheat indication disables all switches until it clears.
// - After overheat clears, bridge operation resumes without host action.
// - Supply lockout disables everything and resets logic until supply returns.
// - Missing logic supply leaves a low-power state drawing little current.
// - Inputs decode to coast, reverse, forward or brake.
module hbfs_ctrl
  import hbfs_pkg::*;
(
  input wire logic core_clk, // Core clock, 100 MHz
  input wire logic rst, // Async reset, active high
  input wire logic low_power_request_n, // Sleep request, active low
  input wire logic bridge_input_a, // Host bridge input a
  input wire logic bridge_input_b, // Host bridge input b
  input wire logic [SWITCH_COUNT-1:0] switch_limit, // Limit flags: a-hi, a-lo, b-hi, b-lo
  input wire logic overheat_shutdown, // Die overtemperature indication
  input wire logic supply_low_lockout, // Logic supply below threshold
  output logic [1:0] drive_a, // Switch drive for output a
  output logic [1:0] drive_b, // Switch drive for output b
  output logic bridge_output_a_oe, // Output a driven
  output logic bridge_output_b_oe, // Output b driven
  output logic bridge_output_a_o, // Output a level when driven
  output logic bridge_output_b_o, // Output b level when driven
  output logic overcurrent_trip, // Overcurrent shutdown active
  output logic core_awake // Internal circuitry powered
);
  import hbfs_pkg::*;

  hbfs_state_t state_r;
  hbfs_state_t state_nxt;
  logic [RETRY_WIDTH-1:0] retry_r;
  logic [SWITCH_COUNT-1:0] qual;
  logic any_fault;
  logic lrst;
  logic run_ok;

  // Lockout behaves as an extra reset so no stale state survives a brownout
  assign lrst = rst || supply_low_lockout;

  genvar g;
  generate
    for (g = 0; g < SWITCH_COUNT; g++) begin : g_qual
      hbfs_qual u_qual (
        .core_clk(core_clk),
        .rst(rst),
        .clr(supply_low_lockout || state_r != HBFS_RUN),
        .limit_active(switch_limit[g]),
        .qualified(qual[g])
      );
    end
  endgenerate

  // Any one of the four switches can trip the whole bridge, so a short to
  // ground, to supply or across the load all end in the same shutdown.
  assign any_fault = |qual;

  // Sleep wins over every fault state. An overheat still present on the last cycle
  // of the retry wait sends it to HOT instead of RUN, so the retry timer never
  // re-enables a bridge that is still too hot.

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HBFS_SLEEP: begin
        if (low_power_request_n) begin
          state_nxt = overheat_shutdown ? HBFS_HOT : HBFS_RUN;
        end
      end
      HBFS_RUN: begin
        if (!low_power_request_n) begin
          state_nxt = HBFS_SLEEP;
        end else if (overheat_shutdown) begin
          state_nxt = HBFS_HOT;
        end else if (any_fault) begin
          state_nxt = HBFS_OC_WAIT;
        end
      end
      HBFS_OC_WAIT: begin
        if (!low_power_request_n) begin
          state_nxt = HBFS_SLEEP;
        end else if (retry_r == RETRY_WIDTH'(RETRY_CYCLES - 1)) begin
          state_nxt = overheat_shutdown ? HBFS_HOT : HBFS_RUN;
        end
      end
      HBFS_HOT: begin
        if (!low_power_request_n) begin
          state_nxt = HBFS_SLEEP;
        end else if (!overheat_shutdown) begin
          state_nxt = HBFS_RUN;
        end
      end
      default: state_nxt = HBFS_SLEEP;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= HBFS_SLEEP;
    end else if (supply_low_lockout) begin
      state_r <= HBFS_SLEEP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Retry timer runs only while waiting out an overcurrent
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      retry_r <= '0;
    end else if (supply_low_lockout || state_r != HBFS_OC_WAIT) begin
      retry_r <= '0;
    end else begin
      retry_r <= retry_r + 1'b1;
    end
  end

  // Drive is enabled only in RUN and only when no shutdown is pending.
  // Using the next state rather than state_r removes one cycle of exposure
  // after a fault, a sleep request or a lockout arrives.
  assign run_ok = state_nxt == HBFS_RUN && !lrst && low_power_request_n;

  // Input decode of the host pin pair
  logic coast;
  logic fwd;
  logic rev;
  logic bridge_on;

  assign coast = !bridge_input_a && !bridge_input_b;
  assign fwd = bridge_input_a && !bridge_input_b;
  assign rev = !bridge_input_a && bridge_input_b;

  // Any shutdown overrides the host pins; coast also releases both legs
  assign bridge_on = run_ok && !coast;

  // Leg a switches: high-side for forward, low-side for reverse and brake.
  // Both switches of a leg are never on together, which avoids shoot-through.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_a <= DRV_OFF;
    end else if (!bridge_on) begin
      drive_a <= DRV_OFF;
    end else begin
      drive_a <= fwd ? DRV_HIGH : DRV_LOW;
    end
  end

  // Leg b switches mirror leg a
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_b <= DRV_OFF;
    end else if (!bridge_on) begin
      drive_b <= DRV_OFF;
    end else begin
      drive_b <= rev ? DRV_HIGH : DRV_LOW;
    end
  end

  // Output enables: high impedance whenever the bridge is off
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bridge_output_a_oe <= 1'b0;
      bridge_output_b_oe <= 1'b0;
    end else begin
      bridge_output_a_oe <= bridge_on;
      bridge_output_b_oe <= bridge_on;
    end
  end

  // Driven levels; held low while undriven so no stale level leaks out
  // when the enable returns.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bridge_output_a_o <= 1'b0;
      bridge_output_b_o <= 1'b0;
    end else begin
      bridge_output_a_o <= bridge_on && fwd;
      bridge_output_b_o <= bridge_on && rev;
    end
  end

  // Trip flag stands for the whole retry wait; lockout clears it at once
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      overcurrent_trip <= 1'b0;
    end else begin
      overcurrent_trip <= state_nxt == HBFS_OC_WAIT && !lrst;
    end
  end

  // Sleep and lockout both gate internal power; covers the no-supply case too.
  // Only the wake path on the sleep pin stays alive while this is low.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_awake <= 1'b0;
    end else begin
      core_awake <= low_power_request_n && !supply_low_lockout;
    end
  end
endmodule

// ==== hbfs_host.sv ====
// Host pin model: sleep request and the two bridge inputs.
// Assumes the bench sets cmd; pins move only just after a clock edge.
module hbfs_host (
  input wire logic core_clk, // Core clock
  input wire logic [2:0] cmd, // {sleep_n, a, b}
  output logic low_power_request_n, // Sleep request
  output logic bridge_input_a, // Input a
  output logic bridge_input_b // Input b
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {low_power_request_n, bridge_input_a, bridge_input_b} = 3'h4;
  always @(posedge core_clk) {low_power_request_n, bridge_input_a, bridge_input_b} <= cmd;
endmodule

// ==== hbfs_ctrl_chk.sv ====
// Port assertions for the H-bridge controller.
// Assumes one clock domain; bound to every hbfs_ctrl instance.
module hbfs_ctrl_chk
  import hbfs_pkg::*;
(
  input wire logic core_clk, rst, low_power_request_n, bridge_input_a, bridge_input_b,
  input wire logic [SWITCH_COUNT-1:0] switch_limit,
  input wire logic overheat_shutdown, supply_low_lockout, overcurrent_trip, core_awake,
  input wire logic [1:0] drive_a, drive_b,
  input wire logic bridge_output_a_oe, bridge_output_b_oe, bridge_output_a_o, bridge_output_b_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire run_ok = low_power_request_n && !overheat_shutdown && !supply_low_lockout &&
    !overcurrent_trip && switch_limit == '0;
  wire off = {bridge_output_a_oe, bridge_output_b_oe, drive_a, drive_b} == 6'h00;
  wire [7:0] outs = {bridge_output_a_oe, bridge_output_b_oe, bridge_output_a_o,
    bridge_output_b_o, drive_a, drive_b};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_sleep_off: assert property (!low_power_request_n |=> off && !core_awake)
    else $error("sleep left bridge on");
  chk_lock_off: assert property (supply_low_lockout |=> off && !core_awake)
    else $error("lockout left bridge on");
  chk_hot_off: assert property (overheat_shutdown |=> off)
    else $error("overheat left bridge on");
  chk_trip_off: assert property (overcurrent_trip |-> off)
    else $error("trip with bridge on");
  chk_trip_cause: assert property ($rose(overcurrent_trip) |-> $past(|switch_limit))
    else $error("trip without limit");
  chk_trip_hold: assert property ($rose(overcurrent_trip) |-> overcurrent_trip[*8])
    else $error("retry ended early");
  chk_fwd_out: assert property (run_ok && bridge_input_a && !bridge_input_b |=> outs == 8'he9)
    else $error("forward decode wrong");
  chk_rev_out: assert property (run_ok && !bridge_input_a && bridge_input_b |=> outs == 8'hd6)
    else $error("reverse decode wrong");
  chk_brake_out: assert property (run_ok && bridge_input_a && bridge_input_b |=> outs == 8'hc5)
    else $error("brake decode wrong");
  cover property (overcurrent_trip);
  cover property ($fell(overheat_shutdown) ##2 bridge_output_a_oe);
  cover property (!low_power_request_n ##1 !core_awake);
endmodule
bind hbfs_ctrl hbfs_ctrl_chk chk_u (.*);

// ==== hbfs_ctrl_tb.sv ====
// Self-checking bench for the H-bridge controller with a host pin model.
// Assumes the checker binds itself; one overcurrent retry runs its full 1 ms.
module hbfs_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import hbfs_pkg::*;
  logic core_clk = 0, rst = 1, overheat_shutdown = 0, supply_low_lockout = 0;
  logic [3:0] switch_limit = '0;
  logic [2:0] cmd = 3'h4;
  logic low_power_request_n, bridge_input_a, bridge_input_b, overcurrent_trip, core_awake;
  logic bridge_output_a_oe, bridge_output_b_oe, bridge_output_a_o, bridge_output_b_o;
  logic [1:0] drive_a, drive_b;
  logic [7:0] dec [4] = '{8'h00, 8'hd6, 8'he9, 8'hc5};
  int failures = 0, n_compared = 0, n;
  // Level is masked while undriven, since a floating output has no defined value
  wire [7:0] outs = {bridge_output_a_oe, bridge_output_b_oe, bridge_output_a_o & bridge_output_a_oe,
    bridge_output_b_o & bridge_output_b_oe, drive_a, drive_b};
  hbfs_ctrl dut_u (.*);
  hbfs_host host_u (.*);
  initial forever #5 core_clk = ~core_clk;
  task go(int c);
    repeat (c) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task cmp8(logic [7:0] g, logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t outputs %h want %h", $time, g, e);
    end
  endtask
  task cmp1(logic g, logic e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t flag %b want %b", $time, g, e);
    end
  endtask
  task t_decode;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk) cmd <= {1'b1, 2'(i)};
      go(3);
      cmp8(outs, dec[i]);
    end
  endtask
  task t_sleep;
    @(posedge core_clk) cmd <= 3'h3;
    go(3);
    cmp8(outs, 8'h00);
    cmp1(core_awake, 1'b0);
  endtask
  task t_hot;
    @(posedge core_clk) cmd <= 3'h6;
    overheat_shutdown <= 1;
    go(3);
    cmp8(outs, 8'h00);
    cmp1(core_awake, 1'b1);
    @(posedge core_clk) overheat_shutdown <= 0;
    go(2);
    cmp8(outs, 8'he9);
  endtask
  task t_lock;
    @(posedge core_clk) supply_low_lockout <= 1;
    go(2);
    cmp8(outs, 8'h00);
    cmp1(core_awake, 1'b0);
    @(posedge core_clk) supply_low_lockout <= 0;
    go(3);
    cmp8(outs, 8'he9);
    cmp1(core_awake, 1'b1);
  endtask
  task t_oc(int k, bit full);
    @(posedge core_clk) switch_limit[k] <= 1;
    n = 0;
    do begin go(1); n++; end while (overcurrent_trip !== 1'b1 && n < 400);
    cmp1(logic'(n >= QUAL_CYCLES && n <= QUAL_CYCLES + 4), 1'b1);
    cmp8(outs, 8'h00);
    @(posedge core_clk) switch_limit <= '0;
    if (full) begin
      n = 0;
      do begin go(1); n++; end while (overcurrent_trip === 1'b1 && n < RETRY_CYCLES + 9);
      cmp1(logic'(n >= RETRY_CYCLES - 4 && n <= RETRY_CYCLES + 4), 1'b1);
      go(1);
      cmp8(outs, 8'he9);
    end else begin
      go(9);
      t_lock();
      cmp1(overcurrent_trip, 1'b0);
    end
  endtask
  task print_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (110000) @(posedge core_clk);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 0;
    t_decode();
    t_sleep();
    t_hot();
    t_lock();
    t_oc(0, 0);
    t_oc(3, 1);
    print_verdict();
  end
endmodule
